// file: rtl/qcrs_sequencer.sv
// Readout sequencer driving a four-quadrant full-frame CCD and sampling its video.
// Assumes ADC words per quadrant arrive synchronous to clk_sys_in, settled each cycle.
//
// Operation
// - Both vertical phases stay low during the whole integration period.
// - Row moves on vertical phase two falling while horizontal phase one is high.
// - Outside reset, horizontal phases one and two toggle as exact complements.
// - Reset gate pulses after the signal sample, before the next packet.
// - Dummy cells never enter the dark reference average.
// - Dark average skips the first two and last two dark pixels of each line.
module qcrs_sequencer
  import qcrs_pkg::*;
#(
  parameter int COLS       = COLS_PER_Q,
  parameter int ROWS       = ROWS_PER_Q,
  parameter int VPHASE_LEN = VPHASE_CYC
) (
  // Clock and reset
  input  wire logic                           clk_sys_in,
  input  wire logic                           reset_n_in,
  // Control
  input  wire logic                           start_in,
  input  wire logic [TIMER_W-1:0]             integ_cycles_in,
  output logic                                busy_out,
  output logic                                frame_done_out,
  // Sensor drive
  output qcrs_drive_t                         drive_out,
  // Video samples
  input  wire logic [QUADS-1:0][SAMPLE_W-1:0] video_output_in,
  // Pixel stream
  output logic                                pix_valid_out,
  output qcrs_word_t                          pix_out,
  input  wire logic                           pix_ready_in,
  // Dark reference
  output logic [QUADS-1:0][SAMPLE_W-1:0]      dark_level_out
);

  localparam logic [CNT_W-1:0] LAST_COL   = CNT_W'(COLS - 1);
  localparam logic [CNT_W-1:0] LAST_ROW   = CNT_W'(ROWS - 1);
  localparam logic [CNT_W-1:0] DARK_C0    = CNT_W'(DUMMY_COLS);
  localparam logic [CNT_W-1:0] BUF_C0     = CNT_W'(DUMMY_COLS + DARK_COLS);
  localparam logic [CNT_W-1:0] ACT_C0     = CNT_W'(DUMMY_COLS + DARK_COLS + BUFFER_COLS);
  localparam logic [CNT_W-1:0] AVG_C0     = CNT_W'(DUMMY_COLS + DARK_SKIP);
  localparam logic [CNT_W-1:0] AVG_C1     = CNT_W'(DUMMY_COLS + DARK_COLS - DARK_SKIP);
  localparam logic [CNT_W-1:0] BUF_R0     = CNT_W'(DARK_ROWS);
  localparam logic [CNT_W-1:0] ACT_R0     = CNT_W'(DARK_ROWS + BUFFER_ROWS);
  localparam logic [TIMER_W-1:0] VPH_LOAD = TIMER_W'(VPHASE_LEN - 1);

  qcrs_state_t                    state_reg;
  qcrs_state_t                    state_next;
  logic [TIMER_W-1:0]             timer_reg;
  logic [1:0]                     ph_reg;
  logic [CNT_W-1:0]               col_reg;
  logic [CNT_W-1:0]               row_reg;
  logic [QUADS-1:0][SAMPLE_W-1:0] ref_level_reg;
  logic [QUADS-1:0][ACC_W-1:0]    dark_acc_reg;
  qcrs_drive_t                    drive_next;
  qcrs_word_t                     word;
  logic [QUADS-1:0][SAMPLE_W-1:0] diff;
  logic                           tick;
  logic                           buf_ready;
  logic                           push;
  logic                           line_end;
  logic                           frame_end;
  logic                           in_avg;

  assign tick      = (timer_reg == '0);
  assign push      = (state_reg == QCRS_PIX) && (ph_reg == PH_SIGSMP) && buf_ready;
  assign line_end  = (col_reg == LAST_COL);
  assign frame_end = line_end && (row_reg == LAST_ROW);
  assign in_avg    = (col_reg >= AVG_C0) && (col_reg < AVG_C1);

  // ==========================================================
  // State sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      QCRS_IDLE:  if (start_in) state_next = QCRS_INTEG;
      QCRS_INTEG: if (tick) state_next = QCRS_V1UP;
      QCRS_V1UP:  if (tick) state_next = QCRS_V2UP;
      QCRS_V2UP:  if (tick) state_next = QCRS_V1DN;
      QCRS_V1DN:  if (tick) state_next = QCRS_V2DN;
      QCRS_V2DN:  if (tick) state_next = QCRS_PIX;
      QCRS_PIX: begin
        if (push && frame_end) begin
          state_next = QCRS_DONE;
        end else if (push && line_end) begin
          state_next = QCRS_V1UP;
        end
      end
      QCRS_DONE:  state_next = QCRS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= QCRS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Dwell timer
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_reg <= '0;
    end else if (state_reg == QCRS_IDLE) begin
      timer_reg <= integ_cycles_in;
    end else if (state_next != state_reg) begin
      timer_reg <= VPH_LOAD;
    end else if (!tick) begin
      timer_reg <= timer_reg - 1'b1;
    end
  end

  // ==========================================================
  // Pixel sub-step and position counters
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ph_reg  <= PH_RESET;
      col_reg <= '0;
      row_reg <= '0;
    end else if (state_reg == QCRS_IDLE) begin
      ph_reg  <= PH_RESET;
      col_reg <= '0;
      row_reg <= '0;
    end else if (state_reg == QCRS_PIX) begin
      if (ph_reg != PH_SIGSMP) begin
        ph_reg <= ph_reg + 2'h1;
      end else if (push) begin
        ph_reg  <= PH_RESET;
        col_reg <= line_end ? '0 : col_reg + 1'b1;
        if (line_end) begin
          row_reg <= row_reg + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Phase drive
  always_comb begin
    drive_next = '0;
    unique case (state_reg)
      QCRS_IDLE, QCRS_INTEG, QCRS_DONE: begin
        drive_next.horizontal_phase_two  = '1;
      end
      QCRS_V1UP: begin
        drive_next.vertical_phase_one    = 1'b1;
        drive_next.horizontal_phase_one  = '1;
        drive_next.last_horizontal_phase = '1;
      end
      QCRS_V2UP: begin
        drive_next.vertical_phase_one    = 1'b1;
        drive_next.vertical_phase_two    = 1'b1;
        drive_next.horizontal_phase_one  = '1;
        drive_next.last_horizontal_phase = '1;
      end
      QCRS_V1DN: begin
        drive_next.vertical_phase_two    = 1'b1;
        drive_next.horizontal_phase_one  = '1;
        drive_next.last_horizontal_phase = '1;
      end
      QCRS_V2DN: begin
        drive_next.horizontal_phase_one  = '1;
        drive_next.last_horizontal_phase = '1;
      end
      QCRS_PIX: begin
        if (ph_reg == PH_RESET || ph_reg == PH_REFSMP) begin
          drive_next.horizontal_phase_one  = '1;
          drive_next.last_horizontal_phase = '1;
        end else begin
          drive_next.horizontal_phase_two  = '1;
        end
        if (ph_reg == PH_RESET) begin
          drive_next.reset_gate = '1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_out <= '0;
    end else begin
      drive_out <= drive_next;
    end
  end

  // ==========================================================
  // Correlated sampling, all quadrants at once
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_level_reg <= '0;
    end else if (state_reg == QCRS_PIX && ph_reg == PH_DUMP) begin
      ref_level_reg <= video_output_in;
    end
  end

  always_comb begin
    for (int q = 0; q < QUADS; q++) begin
      diff[q] = (ref_level_reg[q] > video_output_in[q]) ?
                ref_level_reg[q] - video_output_in[q] : '0;
    end
  end

  // ==========================================================
  // Word tagging
  always_comb begin
    word               = '0;
    word.value         = diff;
    word.line_dark     = (row_reg < BUF_R0);
    word.line_buffer   = (row_reg >= BUF_R0) && (row_reg < ACT_R0);
    word.last_in_line  = line_end;
    word.last_in_frame = frame_end;
    if (col_reg < DARK_C0) begin
      word.cls = QCRS_CLS_DUMMY;
    end else if (col_reg < BUF_C0) begin
      word.cls = QCRS_CLS_DARK;
    end else if (col_reg < ACT_C0) begin
      word.cls = QCRS_CLS_BUFFER;
    end else begin
      word.cls = QCRS_CLS_ACTIVE;
    end
  end

  // ==========================================================
  // Dark reference per line
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dark_acc_reg   <= '0;
      dark_level_out <= '0;
    end else if (push) begin
      for (int q = 0; q < QUADS; q++) begin
        if (col_reg == AVG_C1) begin
          dark_level_out[q] <= dark_acc_reg[q][ACC_W-1:DARK_SHIFT];
          dark_acc_reg[q]   <= '0;
        end else if (in_avg) begin
          dark_acc_reg[q] <= dark_acc_reg[q] + ACC_W'(diff[q]);
        end
      end
    end
  end

  // ==========================================================
  // Status
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out       <= 1'b0;
      frame_done_out <= 1'b0;
    end else begin
      busy_out       <= (state_next != QCRS_IDLE);
      frame_done_out <= (state_next == QCRS_DONE);
    end
  end

  // ==========================================================
  // Output buffer; a stall holds the sequencer in the signal-sample step
  qcrs_skid #(
    .WIDTH (WORD_W)
  ) u_skid (
    .clk_sys_in    (clk_sys_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (state_reg == QCRS_PIX && ph_reg == PH_SIGSMP),
    .in_data_in    (word),
    .in_ready_out  (buf_ready),
    .out_valid_out (pix_valid_out),
    .out_data_out  (pix_out),
    .out_ready_in  (pix_ready_in)
  );

endmodule

// file: rtl/qcrs_pkg.sv
// Shared constants and carriers for the quadrant CCD readout sequencer.
// Assumes a single 25 MHz system clock and an ADC word per quadrant per cycle.
package qcrs_pkg;

  // ==========================================================
  // Geometry
  localparam int QUADS        = 4;
  localparam int SAMPLE_W     = 16;
  localparam int COLS_PER_Q   = 1546;
  localparam int ROWS_PER_Q   = 1536;
  localparam int DUMMY_COLS   = 10;
  localparam int DARK_COLS    = 20;
  localparam int BUFFER_COLS  = 4;
  localparam int DARK_ROWS    = 20;
  localparam int BUFFER_ROWS  = 4;
  localparam int DARK_SKIP    = 2;
  localparam int DARK_SHIFT   = 4;
  localparam int CNT_W        = 11;
  localparam int ACC_W        = SAMPLE_W + DARK_SHIFT;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_VPHASE_NS   = 20000;
  localparam int VPHASE_CYC    = (T_VPHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 32;

  // Pixel sub-steps
  localparam logic [1:0] PH_RESET  = 2'h0;
  localparam logic [1:0] PH_REFSMP = 2'h1;
  localparam logic [1:0] PH_DUMP   = 2'h2;
  localparam logic [1:0] PH_SIGSMP = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    QCRS_IDLE  = 3'b000,
    QCRS_INTEG = 3'b001,
    QCRS_V1UP  = 3'b010,
    QCRS_V2UP  = 3'b011,
    QCRS_V1DN  = 3'b100,
    QCRS_V2DN  = 3'b101,
    QCRS_PIX   = 3'b110,
    QCRS_DONE  = 3'b111
  } qcrs_state_t;

  typedef enum logic [1:0] {
    QCRS_CLS_DUMMY  = 2'b00,
    QCRS_CLS_DARK   = 2'b01,
    QCRS_CLS_BUFFER = 2'b10,
    QCRS_CLS_ACTIVE = 2'b11
  } qcrs_cls_t;

  typedef struct packed {
    logic             vertical_phase_one;
    logic             vertical_phase_two;
    logic [QUADS-1:0] horizontal_phase_one;
    logic [QUADS-1:0] horizontal_phase_two;
    logic [QUADS-1:0] last_horizontal_phase;
    logic [QUADS-1:0] reset_gate;
  } qcrs_drive_t;

  typedef struct packed {
    logic [QUADS-1:0][SAMPLE_W-1:0] value;
    qcrs_cls_t                      cls;
    logic                           line_dark;
    logic                           line_buffer;
    logic                           last_in_line;
    logic                           last_in_frame;
  } qcrs_word_t;

  localparam int WORD_W = $bits(qcrs_word_t);

endpackage

// file: rtl/qcrs_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; outputs come straight from flip-flops.
module qcrs_skid
  import qcrs_pkg::*;
#(
  parameter int WIDTH = WORD_W
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  logic             skid_valid_reg;
  logic [WIDTH-1:0] skid_data_reg;
  logic             take;
  logic             drain;

  assign take  = in_valid_in && in_ready_out;
  assign drain = out_valid_out && out_ready_in;

  // ==========================================================
  // Main stage
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (!out_valid_out || drain) begin
      if (skid_valid_reg) begin
        out_valid_out <= 1'b1;
        out_data_out  <= skid_data_reg;
      end else begin
        out_valid_out <= take;
        if (take) begin
          out_data_out <= in_data_in;
        end
      end
    end
  end

  // ==========================================================
  // Skid stage
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      skid_valid_reg <= 1'b0;
      skid_data_reg  <= '0;
      in_ready_out   <= 1'b0;
    end else begin
      if (skid_valid_reg && (!out_valid_out || drain)) begin
        skid_valid_reg <= take;
        if (take) begin
          skid_data_reg <= in_data_in;
        end
        in_ready_out <= 1'b1;
      end else if (!skid_valid_reg && take && out_valid_out && !drain) begin
        skid_valid_reg <= 1'b1;
        skid_data_reg  <= in_data_in;
        in_ready_out   <= 1'b0;
      end else begin
        in_ready_out <= !skid_valid_reg;
      end
    end
  end

endmodule

// file: sim/qcrs_sva.sv
// Port checker for the quadrant readout sequencer, attached by bind.
// Assumes one clock domain and the asynchronous active-low reset.
module qcrs_sva
  import qcrs_pkg::*;
#(
  parameter int COLS       = COLS_PER_Q,
  parameter int ROWS       = ROWS_PER_Q,
  parameter int VPHASE_LEN = VPHASE_CYC
) (
  input wire logic                           clk_sys_in,
  input wire logic                           reset_n_in,
  input wire logic                           start_in,
  input wire logic [TIMER_W-1:0]             integ_cycles_in,
  input wire logic                           busy_out,
  input wire logic                           frame_done_out,
  input wire qcrs_drive_t                    drive_out,
  input wire logic [QUADS-1:0][SAMPLE_W-1:0] video_output_in,
  input wire logic                           pix_valid_out,
  input wire qcrs_word_t                     pix_out,
  input wire logic                           pix_ready_in,
  input wire logic [QUADS-1:0][SAMPLE_W-1:0] dark_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic settled_reg;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // Drive valid from the second edge after reset
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) settled_reg <= 1'b0;
    else settled_reg <= 1'b1;
  end
  // ==========================================================
  // Assertions
  AST_IDLE_V_LOW: assert property (!busy_out |->
    !drive_out.vertical_phase_one && !drive_out.vertical_phase_two)
    else $error("vertical high idle");
  AST_INTEG_V_LOW: assert property ($rose(busy_out) |->
    (!drive_out.vertical_phase_one && !drive_out.vertical_phase_two)[*3])
    else $error("early vertical");
  AST_ROW_ON_H1: assert property ($fell(drive_out.vertical_phase_two) |->
    &drive_out.horizontal_phase_one) else $error("row moved with phase one low");
  AST_V_ORDER: assert property ($rose(drive_out.vertical_phase_two) |->
    drive_out.vertical_phase_one) else $error("vertical phase order");
  AST_H_COMPL: assert property (settled_reg |->
    drive_out.horizontal_phase_one == ~drive_out.horizontal_phase_two)
    else $error("not complement");
  AST_QUADS_EQ: assert property (settled_reg |->
    drive_out.last_horizontal_phase == {QUADS{drive_out.last_horizontal_phase[0]}} &&
    drive_out.reset_gate == {QUADS{drive_out.reset_gate[0]}}) else $error("quadrants differ");
  AST_RG_BEFORE_DUMP: assert property ($fell(drive_out.last_horizontal_phase[0]) |->
    $past(drive_out.reset_gate[0], 2) && !drive_out.reset_gate[0])
    else $error("dump without reset");
  AST_RG_PULSE: assert property ($rose(drive_out.reset_gate[0]) |=>
    !drive_out.reset_gate[0] && drive_out.last_horizontal_phase[0])
    else $error("reset pulse shape");
  AST_START_BUSY: assert property (start_in && !busy_out && !frame_done_out |=> busy_out)
    else $error("start not taken");
  AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> $past(start_in))
    else $error("busy uncaused");
  // Busy still high in the done cycle, both low one cycle later
  AST_DONE_PULSE: assert property (frame_done_out |-> busy_out ##1 (!busy_out && !frame_done_out))
    else $error("done not a pulse");
  AST_STALL_HOLD: assert property (pix_valid_out && !pix_ready_in |=>
    pix_valid_out && $stable(pix_out)) else $error("word lost in stall");
  COV_ROW: cover property ($fell(drive_out.vertical_phase_two));
  COV_STALL: cover property ((pix_valid_out && !pix_ready_in)[*8]);
  COV_DONE: cover property (frame_done_out);
endmodule

bind qcrs_sequencer qcrs_sva #(.COLS(COLS), .ROWS(ROWS), .VPHASE_LEN(VPHASE_LEN)) qcrs_sva_i (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .start_in(start_in),
  .integ_cycles_in(integ_cycles_in), .busy_out(busy_out), .frame_done_out(frame_done_out),
  .drive_out(drive_out), .video_output_in(video_output_in), .pix_valid_out(pix_valid_out),
  .pix_out(pix_out), .pix_ready_in(pix_ready_in), .dark_level_out(dark_level_out));

// file: sim/qcrs_ccd_model.sv
// Behavioural four-quadrant sensor: packets, floating diffusion and video.
// Assumes the bench supplies a random scene and holds idle_in between frames.
module qcrs_ccd_model
  import qcrs_pkg::*;
#(
  parameter logic [SAMPLE_W-1:0] RST_LVL = 16'hC000
) (
  // Bench side
  input  wire logic                           clk_sys_in,
  input  wire logic                           idle_in,
  input  wire logic [QUADS-1:0][SAMPLE_W-1:0] scene_in,
  // Sensor pins
  input  wire qcrs_drive_t                    drive_in,
  output logic [QUADS-1:0][SAMPLE_W-1:0]      video_output_out,
  // Packet tap
  output logic                                dump_out,
  output logic [QUADS-1:0][SAMPLE_W-1:0]      pkt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int                             col_reg     = 0;
  int                             row_reg     = 0;
  logic                           hl_prev_reg = 1'b0;
  logic                           v2_prev_reg = 1'b0;
  logic [QUADS-1:0][SAMPLE_W-1:0] fd_reg      = '0;
  assign dump_out = hl_prev_reg & ~drive_in.last_horizontal_phase[0];
  always_comb begin
    for (int q = 0; q < QUADS; q++) begin
      if (col_reg < DUMMY_COLS) pkt_out[q] = '0;
      else if (row_reg <= DARK_ROWS || col_reg < DUMMY_COLS + DARK_COLS)
        pkt_out[q] = scene_in[q] & 16'h00FF;
      else pkt_out[q] = scene_in[q] & 16'h3FFF;
      video_output_out[q] = RST_LVL - (dump_out ? pkt_out[q] : fd_reg[q]);
    end
  end
  always @(posedge clk_sys_in) begin
    hl_prev_reg <= drive_in.last_horizontal_phase[0];
    v2_prev_reg <= drive_in.vertical_phase_two;
    if (drive_in.reset_gate[0]) fd_reg <= '0;
    else if (dump_out) fd_reg <= pkt_out;
    if (idle_in) begin
      row_reg <= 0;
      col_reg <= 0;
    end else if (v2_prev_reg && !drive_in.vertical_phase_two &&
                 drive_in.horizontal_phase_one[0]) begin
      row_reg <= row_reg + 1;
      col_reg <= 0;
    end else if (dump_out) col_reg <= col_reg + 1;
  end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the quadrant readout sequencer and a sensor model.
// Assumes shortened geometry and vertical timing set by parameters below.
module testbench
  import qcrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCOLS = 40;
  localparam int TROWS = 26;
  logic clk_sys_in, reset_n_in, start_in, busy_out, frame_done_out, pix_valid_out, pix_ready_in;
  logic                           hold_ready, dump;
  logic [TIMER_W-1:0]             integ_cycles_in;
  logic [QUADS-1:0][SAMPLE_W-1:0] video, dark_level_out, scene, pkt;
  qcrs_drive_t                    drive_out, snap;
  qcrs_word_t                     pix_out, exp_w;
  logic [QUADS-1:0][SAMPLE_W-1:0] pq[$];
  int n_errors = 0, n_tests = 0, seed = 32'hFEC0, col = 0, row = 0, words = 0;
  int dsum[QUADS] = '{default: 0};
  qcrs_sequencer #(.COLS(TCOLS), .ROWS(TROWS), .VPHASE_LEN(2)) qcrs_sequencer_i (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .start_in(start_in),
    .integ_cycles_in(integ_cycles_in), .busy_out(busy_out), .frame_done_out(frame_done_out),
    .drive_out(drive_out), .video_output_in(video), .pix_valid_out(pix_valid_out),
    .pix_out(pix_out), .pix_ready_in(pix_ready_in), .dark_level_out(dark_level_out));
  qcrs_ccd_model qcrs_ccd_model_i (.clk_sys_in(clk_sys_in), .idle_in(!busy_out),
    .scene_in(scene), .drive_in(drive_out), .video_output_out(video), .dump_out(dump),
    .pkt_out(pkt));
  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Clock, stimulus and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    scene <= {$random(seed), $random(seed)};
    pix_ready_in <= hold_ready ? 1'b0 : 1'($random(seed));
  end
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_errors++;
    $display("FAIL watchdog expired");
    complete_run();
  end
  // ==========================================================
  // Reference model of the pixel stream
  always @(posedge clk_sys_in) begin
    if (dump) pq.push_back(pkt);
    if (reset_n_in && pix_valid_out && pix_ready_in) begin
      exp_w.value = pq.pop_front();
      exp_w.cls = col < DUMMY_COLS ? QCRS_CLS_DUMMY : col < DUMMY_COLS + DARK_COLS ? QCRS_CLS_DARK
                : col < DUMMY_COLS + DARK_COLS + BUFFER_COLS ? QCRS_CLS_BUFFER : QCRS_CLS_ACTIVE;
      exp_w.line_dark = row < DARK_ROWS;
      exp_w.line_buffer = row >= DARK_ROWS && row < DARK_ROWS + BUFFER_ROWS;
      exp_w.last_in_line = col == TCOLS - 1;
      exp_w.last_in_frame = exp_w.last_in_line && row == TROWS - 1;
      check("pixel word", pix_out, exp_w);
      for (int q = 0; q < QUADS; q++) begin
        if (col >= DUMMY_COLS + DARK_SKIP && col < DUMMY_COLS + DARK_COLS - DARK_SKIP)
          dsum[q] += exp_w.value[q];
        if (col == DUMMY_COLS + DARK_COLS)
          check("dark level", dark_level_out[q], dsum[q] >> DARK_SHIFT);
      end
      words++;
      col++;
      if (col == TCOLS) begin
        col = 0;
        dsum = '{default: 0};
        row = (row + 1) % TROWS;
      end
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    start_in = 1'b0;
    hold_ready = 1'b0;
    integ_cycles_in = '0;
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    #1 check("idle drive", drive_out, qcrs_drive_t'({2'h0, 4'h0, 4'hF, 4'h0, 4'h0}));
    @(posedge clk_sys_in);
    integ_cycles_in <= 32'h3 + 32'($random(seed) & 7);
    start_in <= 1'b1;
    @(posedge clk_sys_in iff frame_done_out === 1'b1);
    repeat (2) @(posedge clk_sys_in);
    #1 check("restart", busy_out, 1'b1);
    repeat (2000) @(posedge clk_sys_in);
    hold_ready <= 1'b1;
    repeat (30) @(posedge clk_sys_in);
    snap = drive_out;
    repeat (20) @(posedge clk_sys_in);
    check("stall valid", pix_valid_out, 1'b1);
    check("frozen drive", drive_out, snap);
    hold_ready <= 1'b0;
    @(posedge clk_sys_in iff frame_done_out === 1'b1);
    start_in <= 1'b0;
    repeat (30) @(posedge clk_sys_in);
    check("busy after end", busy_out, 1'b0);
    check("word count", words, 2 * TROWS * TCOLS);
    complete_run();
  end
endmodule
